// ### rtl/ddac_map.svh
`ifndef DDAC_MAP_SVH
`define DDAC_MAP_SVH

// Input word width and the position of its most significant bit.
`define DDAC_WORD_W      10
`define DDAC_MSB         9
// Largest code; the complementary output carries this minus the code.
`define DDAC_FULL_CODE   10'h3FF
// Weight of one step of the primary output, as a divisor of full scale.
`define DDAC_CODE_STEPS  1024
// Reset value of every data latch and pipeline stage.
`define DDAC_WORD_RST    10'h000
// Converter-clock edges from the input latch to the outputs.
`define DDAC_LATENCY     4
// Segmentation: upper bits drive unary segments, lower bits binary ones.
`define DDAC_SEG_BITS    4
`define DDAC_THERM_W     15
`define DDAC_BIN_W       6
// Highest converter update rate in MSPS that the source may run.
`define DDAC_MAX_MSPS    275
// Least trail of a clock edge after its write edge, in ns.
`define DDAC_CLK_TRAIL_NS 2

`endif

// ### rtl/ddac_pkg.sv
`include "ddac_map.svh"
`default_nettype none

package ddac_pkg;

	// One converter input word, offset binary, bit 9 most significant.
	typedef logic [`DDAC_WORD_W-1:0] ddac_word_t;

	// Bus mode as set by the static mode pin.
	typedef enum logic
	{
		DDAC_MODE_IL   = 1'b0,
		DDAC_MODE_DUAL = 1'b1
	} ddac_mode_t;

	// Interleave pairing state; Gray coded along hold, A, B.
	typedef enum logic [1:0]
	{
		DDAC_SEL_HOLD = 2'b00,
		DDAC_SEL_A    = 2'b01,
		DDAC_SEL_B    = 2'b11
	} ddac_sel_t;

	// Switch drive and output currents of one converter channel.
	typedef struct packed
	{
		logic [`DDAC_THERM_W-1:0] therm_switch;
		logic [`DDAC_BIN_W-1:0]   bin_switch;
		ddac_word_t               primary_current_out;
		ddac_word_t               complement_current_out;
	} ddac_drive_t;

endpackage

`default_nettype wire

// ### rtl/ddac_edge.sv
`include "ddac_map.svh"
`default_nettype none

module ddac_edge
(
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic srst,
	// Sampled strobe and its edge pulses.
	input  wire logic level_in,
	output logic      rise,
	output logic      fall
);

	logic prev_r;

	// Previous level of the strobe, low after reset.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			prev_r <= 1'b0;
		else
			prev_r <= level_in;
	end

	// One-cycle pulses on each transition.
	assign rise = level_in & ~prev_r;
	assign fall = ~level_in & prev_r;

endmodule

`default_nettype wire

// ### rtl/ddac_chan.sv
`include "ddac_map.svh"
`default_nettype none

module ddac_chan
(
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	// Converter latch update and the word it takes.
	input  wire logic                 upd_en,
	input  wire ddac_pkg::ddac_word_t code_in,
	// Decoded switch drive and output currents.
	output ddac_pkg::ddac_drive_t     drive
);

	localparam int STAGES = `DDAC_LATENCY - 1;

	ddac_pkg::ddac_word_t     stage_r [0:STAGES-1];
	ddac_pkg::ddac_drive_t    drive_r;
	ddac_pkg::ddac_word_t     last_word;
	logic [`DDAC_SEG_BITS-1:0] seg_code;
	logic [`DDAC_THERM_W-1:0] therm_nxt;
	ddac_pkg::ddac_drive_t    drive_nxt;

	// Converter latch and delay stages, all advanced by the update clock.
	// R17 fixed latency stages
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			for (int i = 0; i < STAGES; i++)
				stage_r[i] <= `DDAC_WORD_RST;
		end
		else if (upd_en)
		begin
			stage_r[0] <= code_in;
			for (int i = 1; i < STAGES; i++)
				stage_r[i] <= stage_r[i-1];
		end
	end

	assign last_word = stage_r[STAGES-1];
	assign seg_code  = last_word[`DDAC_MSB -: `DDAC_SEG_BITS];

	// R16 unary segment decode
	genvar g;
	generate
		for (g = 0; g < `DDAC_THERM_W; g++)
		begin : g_therm
			assign therm_nxt[g] = seg_code > `DDAC_SEG_BITS'(g);
		end
	endgenerate

	// R18 complementary current split
	assign drive_nxt.therm_switch           = therm_nxt;
	assign drive_nxt.bin_switch             = last_word[`DDAC_BIN_W-1:0];
	assign drive_nxt.primary_current_out    = last_word;
	assign drive_nxt.complement_current_out = `DDAC_FULL_CODE - last_word;

	// Output stage; reset steers all current to the complementary node.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			drive_r.therm_switch           <= '0;
			drive_r.bin_switch             <= '0;
			drive_r.primary_current_out    <= `DDAC_WORD_RST;
			drive_r.complement_current_out <= `DDAC_FULL_CODE;
		end
		else if (upd_en)
			drive_r <= drive_nxt;
	end

	assign drive = drive_r;

endmodule

`default_nettype wire

// ### rtl/ddac_top.sv
// Behaviour
// R01 - Words are unsigned offset binary, bit 9 MSB.
// R02 - Mode pin low interleaved, high dual bus.
// R03 - Update rate up to 275 MSPS accepted.
// R04 - Dual bus: channels fully independent.
// R05 - Write rise loads input latch; clock loads converter.
// R06 - Source keeps write and clock periods equal.
// R07 - Source raises clock first or 2 ns later.
// R08 - Interleaved: A bus only, shared strobes.
// R09 - Select high routes to A, low to B.
// R10 - Unselected input latch recirculates its value.
// R11 - Interleaved words arrive at twice update rate.
// R12 - Capture on write rise, present on fall.
// R13 - Shared clock divided by two for converters.
// R14 - Pairing reset holds divided clock low.
// R15 - Gain select high: both use resistor A.
// R16 - Decode word into segmented current switches.
// R17 - Four clock cycles latency, both modes.
// R18 - Outputs split code over 1024, complement 1023.
// R19 - Select toggles per write, starts at A.
`include "ddac_map.svh"
`default_nettype none

module ddac_top
(
	// Clock and reset.
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	// Static configuration pins.
	input  wire logic                  bus_mode_sel,
	input  wire logic                  gain_set_select,
	// Channel A port; in interleaved mode the shared bus and strobes.
	input  wire ddac_pkg::ddac_word_t  port_a_word,
	input  wire logic                  write_strobe_a,
	input  wire logic                  conv_clock_a,
	// Channel B port; unused in interleaved mode.
	input  wire ddac_pkg::ddac_word_t  port_b_word,
	input  wire logic                  write_strobe_b,
	input  wire logic                  conv_clock_b,
	// Converter drive of both channels.
	output ddac_pkg::ddac_drive_t      chan_a_drive,
	output ddac_pkg::ddac_drive_t      chan_b_drive,
	// Bias resistor feeding each channel: 0 selects A, 1 selects B.
	output logic                       chan_a_bias_src,
	output logic                       chan_b_bias_src,
	// Interleave timing state.
	output logic                       divided_conv_clock,
	output logic                       channel_select,
	output logic                       pairing_reset
);

	////////////////////////////////////////////////////////////////////////
	// Strobe edge detection.

	logic wr_a_rise;
	logic wr_a_fall;
	logic wr_b_rise;
	logic clk_a_rise;
	logic clk_b_rise;

	// The strobes are synchronous samples; edges come from a stored level.
	ddac_edge u_wr_a
	(
		.clk_sys  (clk_sys),
		.srst     (srst),
		.level_in (write_strobe_a),
		.rise     (wr_a_rise),
		.fall     (wr_a_fall)
	);

	ddac_edge u_wr_b
	(
		.clk_sys  (clk_sys),
		.srst     (srst),
		.level_in (write_strobe_b),
		.rise     (wr_b_rise),
		.fall     ()
	);

	ddac_edge u_clk_a
	(
		.clk_sys  (clk_sys),
		.srst     (srst),
		.level_in (conv_clock_a),
		.rise     (clk_a_rise),
		.fall     ()
	);

	ddac_edge u_clk_b
	(
		.clk_sys  (clk_sys),
		.srst     (srst),
		.level_in (conv_clock_b),
		.rise     (clk_b_rise),
		.fall     ()
	);

	////////////////////////////////////////////////////////////////////////
	// Mode decode.

	ddac_pkg::ddac_mode_t mode;
	logic                 mode_dual;
	logic                 mode_il;

	// R02 mode pin decode
	assign mode      = ddac_pkg::ddac_mode_t'(bus_mode_sel);
	assign mode_dual = mode == ddac_pkg::DDAC_MODE_DUAL;
	assign mode_il   = mode == ddac_pkg::DDAC_MODE_IL;

	////////////////////////////////////////////////////////////////////////
	// Pairing reset and channel select.

	logic                pair_rst_r;
	logic                pair_rst_nxt;
	ddac_pkg::ddac_sel_t sel_r;
	ddac_pkg::ddac_sel_t sel_nxt;
	logic                sel_is_a;

	// R14 pairing reset source
	assign pair_rst_nxt = mode_dual;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			pair_rst_r <= 1'b1;
		else
			pair_rst_r <= pair_rst_nxt;
	end

	// R19 select toggles per write
	always_comb
	begin
		sel_nxt = sel_r;
		case (sel_r)
			ddac_pkg::DDAC_SEL_HOLD:
				sel_nxt = ddac_pkg::DDAC_SEL_A;
			ddac_pkg::DDAC_SEL_A:
				if (wr_a_rise)
					sel_nxt = ddac_pkg::DDAC_SEL_B;
			ddac_pkg::DDAC_SEL_B:
				if (wr_a_rise)
					sel_nxt = ddac_pkg::DDAC_SEL_A;
			default:
				sel_nxt = ddac_pkg::DDAC_SEL_HOLD;
		endcase
	end

	// Pairing reset parks the select until it is released.
	always_ff @(posedge clk_sys)
	begin
		if (srst || pair_rst_r)
			sel_r <= ddac_pkg::DDAC_SEL_HOLD;
		else
			sel_r <= sel_nxt;
	end

	assign sel_is_a = sel_r == ddac_pkg::DDAC_SEL_A;

	////////////////////////////////////////////////////////////////////////
	// Input latches.

	ddac_pkg::ddac_word_t in_a_r;
	ddac_pkg::ddac_word_t in_b_r;
	ddac_pkg::ddac_word_t in_a_nxt;
	ddac_pkg::ddac_word_t in_b_nxt;
	logic                 ld_a_il;
	logic                 ld_b_il;
	logic                 ld_a;
	logic                 ld_b;

	// R08 shared A strobe routing
	// R09 select steers the word
	assign ld_a_il = mode_il & wr_a_rise & sel_is_a;
	assign ld_b_il = mode_il & wr_a_rise & ~sel_is_a & ~pair_rst_r;

	// R04 independent channel strobes
	// R05 write rise loads
	assign ld_a = ld_a_il | (mode_dual & wr_a_rise);
	assign ld_b = ld_b_il | (mode_dual & wr_b_rise);

	// R01 MSB kept at bit 9
	// R10 unselected latch recirculates
	assign in_a_nxt = ld_a ? port_a_word : in_a_r;
	assign in_b_nxt = ld_b ? (mode_il ? port_a_word : port_b_word) : in_b_r;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			in_a_r <= `DDAC_WORD_RST;
			in_b_r <= `DDAC_WORD_RST;
		end
		else
		begin
			in_a_r <= in_a_nxt;
			in_b_r <= in_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Word pair presentation.

	ddac_pkg::ddac_word_t pres_a_r;
	ddac_pkg::ddac_word_t pres_b_r;
	ddac_pkg::ddac_word_t conv_a_word;
	ddac_pkg::ddac_word_t conv_b_word;

	// R12 present on write fall
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pres_a_r <= `DDAC_WORD_RST;
			pres_b_r <= `DDAC_WORD_RST;
		end
		else if (mode_il && wr_a_fall)
		begin
			pres_a_r <= in_a_r;
			pres_b_r <= in_b_r;
		end
	end

	// Dual mode feeds the converter latch straight from the input latch.
	assign conv_a_word = mode_il ? pres_a_r : in_a_r;
	assign conv_b_word = mode_il ? pres_b_r : in_b_r;

	////////////////////////////////////////////////////////////////////////
	// Divided converter clock.

	logic div_clk_r;
	logic div_clk_nxt;
	logic div_rise;

	// R13 divide shared clock
	// R11 two words per update
	assign div_clk_nxt = clk_a_rise ? ~div_clk_r : div_clk_r;
	assign div_rise    = mode_il & ~pair_rst_r & clk_a_rise & ~div_clk_r;

	// R14 divided clock held low
	always_ff @(posedge clk_sys)
	begin
		if (srst || pair_rst_r || pair_rst_nxt)
			div_clk_r <= 1'b0;
		else
			div_clk_r <= div_clk_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Converter channels.

	logic upd_a;
	logic upd_b;

	// R05 clock rise updates
	// R03 rate bound by sampling
	assign upd_a = mode_il ? div_rise : clk_a_rise;
	assign upd_b = mode_il ? div_rise : clk_b_rise;

	// R17 latency through channel
	ddac_chan u_chan_a
	(
		.clk_sys (clk_sys),
		.srst    (srst),
		.upd_en  (upd_a),
		.code_in (conv_a_word),
		.drive   (chan_a_drive)
	);

	ddac_chan u_chan_b
	(
		.clk_sys (clk_sys),
		.srst    (srst),
		.upd_en  (upd_b),
		.code_in (conv_b_word),
		.drive   (chan_b_drive)
	);

	////////////////////////////////////////////////////////////////////////
	// Gain set and status outputs.

	logic bias_b_r;
	logic sel_out_r;

	// R15 shared bias resistor
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			bias_b_r <= 1'b1;
		else
			bias_b_r <= ~gain_set_select;
	end

	// Registered view of the channel select.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			sel_out_r <= 1'b0;
		else
			sel_out_r <= sel_nxt == ddac_pkg::DDAC_SEL_A && !pair_rst_nxt;
	end

	// Channel A always uses its own resistor.
	assign chan_a_bias_src    = 1'b0;
	assign chan_b_bias_src    = bias_b_r;
	assign divided_conv_clock = div_clk_r;
	assign channel_select     = sel_out_r;
	assign pairing_reset      = pair_rst_r;

endmodule

`default_nettype wire

// ### bench/ddac_chk.sv
`include "ddac_map.svh"
`default_nettype none

module ddac_chk
(
	// Clock and reset.
	input wire logic                  clk_sys,
	input wire logic                  srst,
	// Static pins and the shared strobes.
	input wire logic                  bus_mode_sel,
	input wire logic                  gain_set_select,
	input wire logic                  conv_clock_a,
	input wire logic                  write_strobe_a,
	// Outputs under watch.
	input wire ddac_pkg::ddac_drive_t chan_a_drive,
	input wire ddac_pkg::ddac_drive_t chan_b_drive,
	input wire logic                  chan_a_bias_src,
	input wire logic                  chan_b_bias_src,
	input wire logic                  divided_conv_clock,
	input wire logic                  channel_select,
	input wire logic                  pairing_reset
);
	timeunit 1ns;
	timeprecision 1ps;

	// Short views of the two output codes.
	wire [9:0] pa = chan_a_drive.primary_current_out;
	wire [9:0] pb = chan_b_drive.primary_current_out;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	// Unary switch pattern for the upper four code bits.
	function automatic logic [14:0] therm(input logic [3:0] u);
		therm = (15'h0001 << u) - 15'h0001;
	endfunction

	////////////////////////////////////////////////////////////////////
	bias_a_fix_a: assert property (!chan_a_bias_src)
		else $error("Bias A source moved.");
	bias_b_gain_a: assert property (
		!$past(srst) |-> chan_b_bias_src == !$past(gain_set_select))
		else $error("Bias B source wrong.");
	code_split_a: assert property (
		chan_a_drive.complement_current_out == `DDAC_FULL_CODE - pa &&
		chan_b_drive.complement_current_out == `DDAC_FULL_CODE - pb)
		else $error("Complement current wrong.");
	switch_dec_a: assert property (
		chan_a_drive.therm_switch == therm(pa[9:6]) &&
		chan_a_drive.bin_switch == pa[5:0])
		else $error("Switch decode wrong.");
	div_hold_a: assert property (
		pairing_reset |-> !divided_conv_clock)
		else $error("Divided clock high in pairing reset.");
	dual_pair_a: assert property (bus_mode_sel |=> pairing_reset)
		else $error("Pairing reset low in dual mode.");
	sel_hold_a: assert property (pairing_reset |-> !channel_select)
		else $error("Select left hold in pairing reset.");
	sel_tog_a: assert property (
		!bus_mode_sel && !$past(pairing_reset) && !pairing_reset &&
		$rose(write_strobe_a) |=> channel_select != $past(channel_select))
		else $error("Select did not toggle on a shared write.");
	sel_start_a: assert property (
		$fell(pairing_reset) |-> channel_select)
		else $error("Select did not start at channel A.");
	div_rise_a: assert property (
		$rose(divided_conv_clock) |->
		$past(conv_clock_a) && !$past(conv_clock_a, 2))
		else $error("Divided clock rose without input rise.");
	div_half_a: assert property (
		$rose(divided_conv_clock) |=> (!$rose(divided_conv_clock)) [*7])
		else $error("Divided clock too fast.");
	dual_upd_a: assert property (
		bus_mode_sel && !$past(srst) && pa != $past(pa) |->
		$past(conv_clock_a) && !$past(conv_clock_a, 2))
		else $error("Dual drive changed off a clock rise.");
	il_upd_a: assert property (
		!bus_mode_sel && !$past(srst) && pa != $past(pa) |->
		$rose(divided_conv_clock))
		else $error("Interleaved drive changed off a divided rise.");

	// Main scenarios reached.
	cover property (bus_mode_sel && pa != $past(pa));
	cover property ($rose(divided_conv_clock));
	cover property (!gain_set_select && chan_b_bias_src);
endmodule

`default_nettype wire

// ### bench/ddac_src.sv
`include "ddac_map.svh"
`default_nettype none

module ddac_src
(
	// Clock and run control.
	input wire logic                 clk_sys,
	input wire logic                 run,
	input wire logic                 il_mode,
	// Words to send.
	input wire ddac_pkg::ddac_word_t word_a,
	input wire ddac_pkg::ddac_word_t word_b,
	// Converter input pins.
	output ddac_pkg::ddac_word_t     port_a_word,
	output ddac_pkg::ddac_word_t     port_b_word,
	output logic                     write_strobe_a,
	output logic                     write_strobe_b,
	output logic                     conv_clock_a,
	output logic                     conv_clock_b
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] ph_r;
	logic       odd_r;
	logic       stb_r;

	// Clock tied to write, so periods match and it never lags.
	assign write_strobe_a = stb_r;
	assign write_strobe_b = stb_r;
	assign conv_clock_a   = stb_r;
	assign conv_clock_b   = stb_r;

	// The source starts idle with its lines low.
	initial
	begin
		ph_r = 2'h0;
		odd_r = 1'b0;
		stb_r = 1'b0;
		port_a_word = 10'h000;
		port_b_word = 10'h000;
	end

	// Four-cycle strobe, two high and two low; words held while high.
	always @(posedge clk_sys)
	begin
		ph_r <= run ? ph_r + 2'h1 : 2'h0;
		stb_r <= run && !ph_r[1];
		if (!run)
			odd_r <= 1'b0;
		// A then B on bus A.
		if (run && ph_r == 2'h0)
		begin
			port_a_word <= (il_mode && odd_r) ? word_b : word_a;
			port_b_word <= il_mode ? ~word_b : word_b;
			odd_r <= il_mode && !odd_r;
		end
		// Released data shows its inverse, not the last value.
		if (ph_r == 2'h2)
		begin
			port_a_word <= ~port_a_word;
			port_b_word <= ~port_b_word;
		end
	end
endmodule

`default_nettype wire

// ### bench/tb_top.sv
`include "ddac_map.svh"
`default_nettype none

`define CHK(nm, ex, sn) \
	begin \
		checks_done++; \
		if ((sn) !== (ex)) \
		begin \
			n_mismatch++; \
			$display("ERROR %s exp %h seen %h", nm, ex, sn); \
		end \
	end

bind ddac_top ddac_chk ddac_chk_i (.clk_sys, .srst, .bus_mode_sel,
	.gain_set_select, .conv_clock_a, .write_strobe_a, .chan_a_drive,
	.chan_b_drive,
	.chan_a_bias_src, .chan_b_bias_src, .divided_conv_clock,
	.channel_select, .pairing_reset);

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed
	{
		logic                 mode;
		logic                 gain;
		ddac_pkg::ddac_word_t wa;
		ddac_pkg::ddac_word_t wb;
		ddac_pkg::ddac_word_t ea;
		ddac_pkg::ddac_word_t eb;
	} ddac_row_t;

	// Mode, gain, words sent, words expected at the outputs.
	ddac_row_t rows [6] = '{
		'{1'b1, 1'b1, 10'h000, 10'h3FF, 10'h000, 10'h3FF},
		'{1'b1, 1'b0, 10'h3FF, 10'h000, 10'h3FF, 10'h000},
		'{1'b1, 1'b1, 10'h200, 10'h1FF, 10'h200, 10'h1FF},
		'{1'b0, 1'b0, 10'h2A5, 10'h15A, 10'h2A5, 10'h15A},
		'{1'b0, 1'b1, 10'h0C3, 10'h33C, 10'h0C3, 10'h33C},
		'{1'b0, 1'b0, 10'h3FF, 10'h001, 10'h3FF, 10'h001}};

	logic                  clk_sys = 1'b0;
	logic                  srst = 1'b1;
	logic                  bus_mode_sel = 1'b1;
	logic                  gain_set_select = 1'b0;
	logic                  run = 1'b0;
	ddac_pkg::ddac_word_t  word_a = 10'h000;
	ddac_pkg::ddac_word_t  word_b = 10'h000;
	ddac_pkg::ddac_word_t  port_a_word, port_b_word;
	logic                  write_strobe_a, write_strobe_b;
	logic                  conv_clock_a, conv_clock_b;
	ddac_pkg::ddac_drive_t chan_a_drive, chan_b_drive;
	logic                  chan_a_bias_src, chan_b_bias_src;
	logic                  divided_conv_clock, channel_select;
	logic                  pairing_reset;
	int                    n_mismatch = 0;
	int                    checks_done = 0;
	int                    n;

	// The 250 MHz system clock.
	always #2 clk_sys = ~clk_sys;

	ddac_top ddac_top_i (.clk_sys, .srst, .bus_mode_sel, .gain_set_select,
		.port_a_word, .write_strobe_a, .conv_clock_a, .port_b_word,
		.write_strobe_b, .conv_clock_b, .chan_a_drive, .chan_b_drive,
		.chan_a_bias_src, .chan_b_bias_src, .divided_conv_clock,
		.channel_select, .pairing_reset);

	ddac_src ddac_src_i (.clk_sys, .run, .il_mode(!bus_mode_sel), .word_a,
		.word_b, .port_a_word, .port_b_word, .write_strobe_a,
		.write_strobe_b, .conv_clock_a, .conv_clock_b);

	// Expected unary switches: bit i set while the top nibble exceeds i.
	function automatic logic [14:0] thermo(input logic [9:0] c);
		thermo = '0;
		for (int i = 0; i < 15; i++)
			thermo[i] = c[9:6] > i;
	endfunction

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Holds reset three cycles, checks the reset state, then releases.
	task automatic do_reset();
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("rst_cmp", 10'h3FF, chan_a_drive.complement_current_out)
		`CHK("rst_div", 1'b0, divided_conv_clock)
		`CHK("rst_pair", 1'b1, pairing_reset)
		`CHK("rst_sel", 1'b0, channel_select)
		@(posedge clk_sys);
		srst <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Cuts a hung run short.
	initial
	begin
		#20000;
		n_mismatch++;
		finish_test();
	end

	// Table rows first, then the latency case.
	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			@(posedge clk_sys);
			run <= 1'b0;
			bus_mode_sel <= rows[i].mode;
			gain_set_select <= rows[i].gain;
			word_a <= rows[i].wa;
			word_b <= rows[i].wb;
			do_reset();
			run <= 1'b1;
			repeat (`DDAC_LATENCY * 20) @(posedge clk_sys);
			#1;
			`CHK("out_a", rows[i].ea, chan_a_drive.primary_current_out)
			`CHK("out_b", rows[i].eb, chan_b_drive.primary_current_out)
			`CHK("cmp_b", 10'h3FF - rows[i].eb,
				chan_b_drive.complement_current_out)
			`CHK("therm_a", thermo(rows[i].ea),
				chan_a_drive.therm_switch)
			`CHK("therm_b", thermo(rows[i].eb),
				chan_b_drive.therm_switch)
			`CHK("bin_b", rows[i].eb[5:0], chan_b_drive.bin_switch)
			`CHK("bias_b", !rows[i].gain, chan_b_bias_src)
			`CHK("pair", rows[i].mode, pairing_reset)
		end
		@(posedge clk_sys);
		run <= 1'b0;
		bus_mode_sel <= 1'b1;
		word_a <= 10'h155;
		word_b <= 10'h0AA;
		do_reset();
		run <= 1'b1;
		repeat (40) @(posedge clk_sys);
		word_a <= 10'h2EA;
		n = 0;
		while (!(write_strobe_a === 1'b1 && port_a_word === 10'h2EA)
			&& n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		while (chan_a_drive.primary_current_out !== 10'h2EA && n < 40);
		`CHK("latency", `DDAC_LATENCY * 4, n)
		`CHK("b_kept", 10'h0AA, chan_b_drive.primary_current_out)
		finish_test();
	end
endmodule

`default_nettype wire
